// >>> hdl/ata_regs_pkg.sv
// Constants, types and register map for the Ata_socket_control / extended index bank
// ----------------------------------------------------------------------------
// Overview of operation
// [R1] Chip information bits 5-0 read back a fixed silicon revision value.
// [R2] Chip information bits 7-6 alternate between two codes on successive reads.
// [R3] Ata_socket_control bit 0 set turns the socket into an ATA drive interface.
// [R4] Bit 1 routes card audio input to the activity lamp in I/O or ATA mode.
// [R5] Software keeps bit 1 clear while a socket runs memory card mode.
// [R6] In ATA mode bits 7-3 drive address pins A25-A21; otherwise only stored.
// [R7] Extended select resets to zero, sits at 2Eh, picks the register behind 2Fh.
// [R8] Extended 03h control 1, 05h-09h window upper address, 25h misc control 3.
// [R9] Extended 34h-3Bh are read-only revision, identity, capability, implementation bytes.
// [R10] Extended 00h is scratchpad; 01h, 02h, 04h, 0Ah are reserved.
// [R11] Data port reads and writes the register chosen by the extended select.
// [R12] Ata_socket_control and extended select are held separately for each socket.
// ----------------------------------------------------------------------------
package ata_regs_pkg;

    // ------------------------------------------------------------------------
    // Primary index map
    // ------------------------------------------------------------------------
    localparam logic [7:0] IDX_CHIP_INFO = 8'h1f;
    localparam logic [7:0] IDX_ATA_CTRL = 8'h26;
    localparam logic [7:0] IDX_EXT_SELECT = 8'h2e;
    localparam logic [7:0] IDX_EXT_DATA = 8'h2f;

    // ------------------------------------------------------------------------
    // Extended index map
    // ------------------------------------------------------------------------
    localparam logic [7:0] EXT_SCRATCH = 8'h00;
    localparam logic [7:0] EXT_CTRL1 = 8'h03;
    localparam logic [7:0] EXT_UPPER_FIRST = 8'h05;
    localparam logic [7:0] EXT_UPPER_LAST = 8'h09;
    localparam logic [7:0] EXT_MISC3 = 8'h25;
    localparam logic [7:0] EXT_ID_FIRST = 8'h34;
    localparam logic [7:0] EXT_ID_LAST = 8'h3b;

    // ------------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------------
    localparam int REV_W = 6;
    localparam int ATA_MODE_BIT = 0;
    localparam int SPK_LAMP_BIT = 1;
    localparam int ADDR_LSB = 3;
    localparam int ADDR_MSB = 7;
    localparam int CTRL1_LAMP_EN_BIT = 2;
    localparam int MISC3_LSB = 6;
    localparam int MISC3_MSB = 7;
    localparam logic [7:0] ATA_CTRL_RESET = 8'h00;
    localparam logic [7:0] EXT_SELECT_RESET = 8'h00;
    localparam logic [7:0] EXT_REG_RESET = 8'h00;

    // ------------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic socket;
        logic [7:0] index;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic ata_addr_top_cable_select;
        logic ata_addr_primary_secondary;
        logic ata_addr_vendor_unique;
        logic ata_addr_a22;
        logic ata_addr_a21;
    } ata_pins_t;

endpackage : ata_regs_pkg

// >>> hdl/ext_reg_file.sv
// Per-socket extended registers reached through the extended data port
`timescale 1ns/100ps
`default_nettype none
module ext_reg_file #(
    parameter int NUM_SOCKETS = 2,
    parameter logic [7:0][7:0] ID_BYTES = 64'h0807060504030201
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic socket,
    input wire logic [7:0] ext_index,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic [NUM_SOCKETS-1:0] lamp_enable
);

    // Socket select is one bit wide
    if (NUM_SOCKETS < 1 || NUM_SOCKETS > 2) begin : g_bad_sockets
        $error("NUM_SOCKETS must be 1 or 2");
    end

    typedef struct packed {
        logic [NUM_SOCKETS-1:0][7:0] scratch;
        logic [NUM_SOCKETS-1:0][7:0] ctrl1;
        logic [NUM_SOCKETS-1:0][4:0][7:0] upper;
        logic [NUM_SOCKETS-1:0][1:0] misc3;
    } ext_state_t;

    ext_state_t s_reg;
    ext_state_t s_next;
    logic [2:0] upper_sel;
    logic [2:0] id_sel;
    logic in_upper;
    logic in_id;

    assign upper_sel = 3'(ext_index - ata_regs_pkg::EXT_UPPER_FIRST);
    assign id_sel = 3'(ext_index - ata_regs_pkg::EXT_ID_FIRST);
    assign in_upper = (ext_index >= ata_regs_pkg::EXT_UPPER_FIRST)
        && (ext_index <= ata_regs_pkg::EXT_UPPER_LAST);
    assign in_id = (ext_index >= ata_regs_pkg::EXT_ID_FIRST)
        && (ext_index <= ata_regs_pkg::EXT_ID_LAST);

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        rdata = 8'h00;
        // [R11] selected register access
        // [R8] control, window and misc decode
        if (ext_index == ata_regs_pkg::EXT_CTRL1) begin
            rdata = s_reg.ctrl1[socket];
            if (wr_en) begin
                s_next.ctrl1[socket] = wdata;
            end
        end else if (in_upper) begin
            rdata = s_reg.upper[socket][upper_sel];
            if (wr_en) begin
                s_next.upper[socket][upper_sel] = wdata;
            end
        end else if (ext_index == ata_regs_pkg::EXT_MISC3) begin
            rdata[ata_regs_pkg::MISC3_MSB:ata_regs_pkg::MISC3_LSB] = s_reg.misc3[socket];
            if (wr_en) begin
                s_next.misc3[socket] = wdata[ata_regs_pkg::MISC3_MSB:ata_regs_pkg::MISC3_LSB];
            end
        end else if (in_id) begin
            // [R9] fixed identity bytes, writes dropped
            rdata = ID_BYTES[id_sel];
        end else if (ext_index == ata_regs_pkg::EXT_SCRATCH) begin
            // [R10] scratchpad; reserved slots read zero
            rdata = s_reg.scratch[socket];
            if (wr_en) begin
                s_next.scratch[socket] = wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    always_comb begin
        for (int k = 0; k < NUM_SOCKETS; k++) begin
            lamp_enable[k] = s_reg.ctrl1[k][ata_regs_pkg::CTRL1_LAMP_EN_BIT];
        end
    end

endmodule : ext_reg_file
`default_nettype wire

// >>> hdl/ata_ctrl_ext_index_regs.sv
// Chip information, per-socket Ata_socket_control and extended index register bank
`timescale 1ns/100ps
`default_nettype none
module ata_ctrl_ext_index_regs #(
    parameter int NUM_SOCKETS = 2,
    // Arbitrary revision value
    parameter logic [ata_regs_pkg::REV_W-1:0] REVISION = 6'h01,
    // Arbitrary identification codes, first and second read
    parameter logic [1:0] ID_FIRST = 2'h2,
    parameter logic [1:0] ID_SECOND = 2'h1,
    // Arbitrary identity bytes for extended 34h..3Bh, byte 0 at 34h
    parameter logic [7:0][7:0] ID_BYTES = 64'h0807060504030201
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire ata_regs_pkg::host_req_t host_req,
    input wire logic [NUM_SOCKETS-1:0] card_io_mode,
    input wire logic [NUM_SOCKETS-1:0] card_cycle_active,
    input wire logic [NUM_SOCKETS-1:0] card_audio_or_lamp_input_n,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic rd_claimed,
    output logic [NUM_SOCKETS-1:0] ata_mode_active,
    output ata_regs_pkg::ata_pins_t [NUM_SOCKETS-1:0] ata_pins,
    output logic [NUM_SOCKETS-1:0] card_audio_input_n,
    output logic activity_lamp_output_n
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    // Socket select is one bit wide
    if (NUM_SOCKETS < 1 || NUM_SOCKETS > 2) begin : g_bad_sockets
        $error("NUM_SOCKETS must be 1 or 2");
    end
    // Equal codes would hide the read toggle
    if (ID_FIRST == ID_SECOND) begin : g_same_codes
        $error("ID_FIRST and ID_SECOND must differ");
    end
    // Code and revision must fill one byte
    if (ata_regs_pkg::REV_W != 6) begin : g_bad_rev_width
        $error("REV_W must be 6");
    end

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_SOCKETS-1:0][7:0] ata_ctrl;
        logic [NUM_SOCKETS-1:0][7:0] ext_select;
        logic id_first;
        logic [7:0] rd_data;
        logic rd_valid;
        logic rd_claimed;
        logic [NUM_SOCKETS-1:0] ata_mode;
        ata_regs_pkg::ata_pins_t [NUM_SOCKETS-1:0] pins;
        logic [NUM_SOCKETS-1:0] audio_n;
        logic lamp_n;
    } bank_state_t;

    bank_state_t s_reg;
    bank_state_t s_next;
    logic sock_ok;
    logic ext_wr;
    logic [7:0] ext_rdata;
    logic [NUM_SOCKETS-1:0] lamp_enable;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [7:0] chip_info_word(input logic first);
        return {(first ? ID_FIRST : ID_SECOND), REVISION};
    endfunction : chip_info_word

    function automatic ata_regs_pkg::ata_pins_t addr_pins(input logic [7:0] ctrl);
        ata_regs_pkg::ata_pins_t p;
        p = ctrl[ata_regs_pkg::ADDR_MSB:ata_regs_pkg::ADDR_LSB];
        return p;
    endfunction : addr_pins

    function automatic logic lamp_routed(input logic [7:0] ctrl, input logic io_mode);
        return ctrl[ata_regs_pkg::SPK_LAMP_BIT]
            && (io_mode || ctrl[ata_regs_pkg::ATA_MODE_BIT]);
    endfunction : lamp_routed

    // Out-of-range socket on a one-socket build touches no per-socket register
    assign sock_ok = (int'(host_req.socket) < NUM_SOCKETS);
    assign ext_wr = host_req.wr && sock_ok && (host_req.index == ata_regs_pkg::IDX_EXT_DATA);

    // ------------------------------------------------------------------------
    // Extended registers
    // ------------------------------------------------------------------------
    ext_reg_file #(
        .NUM_SOCKETS(NUM_SOCKETS),
        .ID_BYTES(ID_BYTES)
    ) u_ext (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .wr_en(ext_wr),
        .socket(host_req.socket),
        .ext_index(s_reg.ext_select[host_req.socket]),
        .wdata(host_req.wdata),
        .rdata(ext_rdata),
        .lamp_enable(lamp_enable)
    );

    // ------------------------------------------------------------------------
    // Host access and pin logic
    // ------------------------------------------------------------------------
    always_comb begin
        logic lamp_on;
        lamp_on = 1'b0;
        s_next = s_reg;
        s_next.rd_valid = 1'b0;

        // --------------------------------------------------------------------
        // Register reads
        // --------------------------------------------------------------------
        if (host_req.rd) begin
            s_next.rd_valid = 1'b1;
            s_next.rd_claimed = 1'b0;
            s_next.rd_data = 8'h00;
            if (host_req.index == ata_regs_pkg::IDX_CHIP_INFO) begin
                // [R1] revision field
                // [R2] alternating identification
                s_next.rd_claimed = 1'b1;
                s_next.rd_data = chip_info_word(s_reg.id_first);
                s_next.id_first = ~s_reg.id_first;
            end else if (sock_ok) begin
                case (host_req.index)
                    ata_regs_pkg::IDX_ATA_CTRL: begin
                        s_next.rd_claimed = 1'b1;
                        s_next.rd_data = s_reg.ata_ctrl[host_req.socket];
                    end
                    ata_regs_pkg::IDX_EXT_SELECT: begin
                        s_next.rd_claimed = 1'b1;
                        s_next.rd_data = s_reg.ext_select[host_req.socket];
                    end
                    ata_regs_pkg::IDX_EXT_DATA: begin
                        // [R11] data port read
                        s_next.rd_claimed = 1'b1;
                        s_next.rd_data = ext_rdata;
                    end
                    default: begin
                        s_next.rd_claimed = 1'b0;
                    end
                endcase
            end
        end

        // --------------------------------------------------------------------
        // Register writes
        // --------------------------------------------------------------------
        if (host_req.wr) begin
            if (host_req.index == ata_regs_pkg::IDX_CHIP_INFO) begin
                // [R2] write restarts the sequence
                s_next.id_first = 1'b1;
            end else if (sock_ok) begin
                case (host_req.index)
                    ata_regs_pkg::IDX_ATA_CTRL: begin
                        // [R12] per-socket copy
                        s_next.ata_ctrl[host_req.socket] = host_req.wdata;
                    end
                    ata_regs_pkg::IDX_EXT_SELECT: begin
                        // [R7] extended select write
                        s_next.ext_select[host_req.socket] = host_req.wdata;
                    end
                    default: begin
                        s_next.id_first = s_next.id_first;
                    end
                endcase
            end
        end

        // --------------------------------------------------------------------
        // Pins and lamp
        // --------------------------------------------------------------------
        for (int k = 0; k < NUM_SOCKETS; k++) begin
            // [R3] ATA mode per socket
            s_next.ata_mode[k] = s_reg.ata_ctrl[k][ata_regs_pkg::ATA_MODE_BIT];
            // [R6] upper address only in ATA mode
            s_next.pins[k] = s_reg.ata_ctrl[k][ata_regs_pkg::ATA_MODE_BIT]
                ? addr_pins(s_reg.ata_ctrl[k]) : '0;
            // [R4] audio input reused as lamp input
            if (lamp_routed(s_reg.ata_ctrl[k], card_io_mode[k])) begin
                s_next.audio_n[k] = 1'b1;
                if (lamp_enable[k] && !card_audio_or_lamp_input_n[k]) begin
                    lamp_on = 1'b1;
                end
            end else begin
                s_next.audio_n[k] = card_audio_or_lamp_input_n[k];
            end
            if (lamp_enable[k] && card_cycle_active[k]) begin
                lamp_on = 1'b1;
            end
        end
        s_next.lamp_n = ~lamp_on;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.ata_ctrl <= {NUM_SOCKETS{ata_regs_pkg::ATA_CTRL_RESET}};
            // [R7] select cleared at reset
            s_reg.ext_select <= {NUM_SOCKETS{ata_regs_pkg::EXT_SELECT_RESET}};
            s_reg.id_first <= 1'b1;
            // Active-low pins idle high
            s_reg.audio_n <= '1;
            s_reg.lamp_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign rd_data = s_reg.rd_data;
    assign rd_valid = s_reg.rd_valid;
    assign rd_claimed = s_reg.rd_claimed;
    assign ata_mode_active = s_reg.ata_mode;
    assign ata_pins = s_reg.pins;
    assign card_audio_input_n = s_reg.audio_n;
    assign activity_lamp_output_n = s_reg.lamp_n;

endmodule : ata_ctrl_ext_index_regs
`default_nettype wire

// >>> tb/card_socket_model.sv
// Socket card model driving mode, activity and lamp pins
`timescale 1ns/100ps
`default_nettype none
module card_socket_model #(
    parameter int NUM_SOCKETS = 2
) (
    input wire logic [NUM_SOCKETS-1:0] io_card,
    input wire logic [NUM_SOCKETS-1:0] busy,
    input wire logic [NUM_SOCKETS-1:0] lamp_on,
    output logic [NUM_SOCKETS-1:0] card_io_mode,
    output logic [NUM_SOCKETS-1:0] card_cycle_active,
    output logic [NUM_SOCKETS-1:0] card_audio_or_lamp_input_n
);
    // Pin has a pull-up, a card only pulls it low
    assign card_audio_or_lamp_input_n = ~lamp_on;
    assign card_io_mode = io_card;
    assign card_cycle_active = busy;
endmodule : card_socket_model
`default_nettype wire

// >>> tb/ata_regs_monitor.sv
// Port assertions for the Ata_socket_control and extended index bank
`timescale 1ns/100ps
`default_nettype none
module ata_regs_monitor #(
    parameter int NUM_SOCKETS = 2,
    parameter logic [ata_regs_pkg::REV_W-1:0] REVISION = 6'h01,
    parameter logic [1:0] ID_FIRST = 2'h2,
    parameter logic [1:0] ID_SECOND = 2'h1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire ata_regs_pkg::host_req_t host_req,
    input wire logic [NUM_SOCKETS-1:0] card_cycle_active,
    input wire logic [NUM_SOCKETS-1:0] card_audio_or_lamp_input_n,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic rd_claimed,
    input wire logic [NUM_SOCKETS-1:0] ata_mode_active,
    input wire ata_regs_pkg::ata_pins_t [NUM_SOCKETS-1:0] ata_pins,
    input wire logic [NUM_SOCKETS-1:0] card_audio_input_n,
    input wire logic activity_lamp_output_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic chip_rd, chip_wr, ata_wr0, mapped, any_busy, any_low, first_reg, chk_reg;
    logic [1:0] exp_reg;
    assign chip_rd = host_req.rd && host_req.index == ata_regs_pkg::IDX_CHIP_INFO;
    assign chip_wr = host_req.wr && host_req.index == ata_regs_pkg::IDX_CHIP_INFO;
    assign ata_wr0 = host_req.wr && host_req.index == ata_regs_pkg::IDX_ATA_CTRL && !host_req.socket;
    assign mapped = host_req.index inside {8'h1f, 8'h26, 8'h2e, 8'h2f};
    assign any_busy = |card_cycle_active;
    assign any_low = ~&card_audio_or_lamp_input_n;
    // Expected code of the next chip read; a write re-arms it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            first_reg <= 1'b1;
            chk_reg <= 1'b0;
            exp_reg <= 2'h0;
        end else begin
            chk_reg <= chip_rd;
            if (chip_rd) begin
                exp_reg <= first_reg ? ID_FIRST : ID_SECOND;
            end
            if (chip_wr) begin
                first_reg <= 1'b1;
            end else if (chip_rd) begin
                first_reg <= ~first_reg;
            end
        end
    end
    sequence sel_write_s;
        host_req.wr && host_req.index == ata_regs_pkg::IDX_EXT_SELECT;
    endsequence
    sequence sel_read_s;
        host_req.rd && host_req.index == ata_regs_pkg::IDX_EXT_SELECT
            && host_req.socket == $past(host_req.socket);
    endsequence
    sequence ata_write_s;
        ata_wr0 ##1 !ata_wr0;
    endsequence
    read_answer_a: assert property (
        1'b1 |=> rd_valid == $past(host_req.rd)) else $error("read answer timing wrong");
    data_hold_a: assert property (
        !rd_valid |-> $stable(rd_data) && $stable(rd_claimed)) else $error("read data moved");
    chip_rev_a: assert property (
        chk_reg |-> rd_data[5:0] == REVISION && rd_claimed) else $error("revision wrong");
    chip_id_a: assert property (
        chk_reg |-> rd_data[7:6] == exp_reg) else $error("identification code wrong");
    ata_mode_a: assert property (
        ata_write_s |=> ata_mode_active[0] == $past(host_req.wdata[0], 2))
        else $error("ATA mode not following bit 0");
    ata_pins_a: assert property (
        ata_write_s |=> ata_pins[0] == ($past(host_req.wdata[0], 2) ?
        $past(host_req.wdata[7:3], 2) : 5'h00)) else $error("address pins wrong");
    sel_back_a: assert property (
        sel_write_s ##1 sel_read_s |=> rd_data == $past(host_req.wdata, 2))
        else $error("select readback wrong");
    unclaimed_a: assert property (
        host_req.rd && !mapped |=> !rd_claimed && rd_data == 8'h00)
        else $error("unmapped index answered");
    audio_cause_a: assert property (
        &(card_audio_input_n | ~$past(card_audio_or_lamp_input_n)))
        else $error("audio output without pin");
    lamp_cause_a: assert property (
        !activity_lamp_output_n |-> $past(any_busy) || $past(any_low))
        else $error("lamp lit without cause");
endmodule : ata_regs_monitor
bind ata_ctrl_ext_index_regs ata_regs_monitor #(.NUM_SOCKETS(NUM_SOCKETS),
    .REVISION(REVISION), .ID_FIRST(ID_FIRST), .ID_SECOND(ID_SECOND)) mon (
    .ref_clk(ref_clk), .rst_n(rst_n), .host_req(host_req),
    .card_cycle_active(card_cycle_active),
    .card_audio_or_lamp_input_n(card_audio_or_lamp_input_n), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_claimed(rd_claimed), .ata_mode_active(ata_mode_active),
    .ata_pins(ata_pins), .card_audio_input_n(card_audio_input_n),
    .activity_lamp_output_n(activity_lamp_output_n));
`default_nettype wire

// >>> tb/ata_ctrl_ext_index_regs_tb.sv
// Self-checking bench for the Ata_socket_control and extended index bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) cmp(8'(a), 8'(e))
module ata_ctrl_ext_index_regs_tb;
    localparam logic [5:0] REV = 6'h01;
    localparam logic [1:0] ID_A = 2'h2;
    localparam logic [1:0] ID_B = 2'h1;
    // Arbitrary identity bytes
    localparam logic [7:0][7:0] IDB = 64'h1122334455667788;
    localparam logic [7:0] CHIP = ata_regs_pkg::IDX_CHIP_INFO;
    localparam logic [7:0] CTRL = ata_regs_pkg::IDX_ATA_CTRL;
    localparam logic [7:0] SEL = ata_regs_pkg::IDX_EXT_SELECT;
    localparam logic [7:0] DAT = ata_regs_pkg::IDX_EXT_DATA;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    ata_regs_pkg::host_req_t host_req = '0;
    logic [1:0] io_card = 2'h0;
    logic [1:0] busy = 2'h0;
    logic [1:0] lamp_on = 2'h0;
    logic [1:0] io_mode, cyc, pin_n, mode, audio_n;
    ata_regs_pkg::ata_pins_t [1:0] pins;
    logic [7:0] rd_data;
    logic rd_valid, rd_claimed, lamp_n;
    int error_cnt = 0;
    int n_compared = 0;
    always #25 ref_clk = ~ref_clk;
    card_socket_model #(.NUM_SOCKETS(2)) card (.io_card(io_card), .busy(busy),
        .lamp_on(lamp_on), .card_io_mode(io_mode), .card_cycle_active(cyc),
        .card_audio_or_lamp_input_n(pin_n));
    ata_ctrl_ext_index_regs #(.NUM_SOCKETS(2), .REVISION(REV), .ID_FIRST(ID_A),
        .ID_SECOND(ID_B), .ID_BYTES(IDB)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .host_req(host_req), .card_io_mode(io_mode), .card_cycle_active(cyc),
        .card_audio_or_lamp_input_n(pin_n), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_claimed(rd_claimed), .ata_mode_active(mode), .ata_pins(pins),
        .card_audio_input_n(audio_n), .activity_lamp_output_n(lamp_n));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // Leaves the write up so a following access lands back to back
    task automatic wr(input logic s, input logic [7:0] i, input logic [7:0] d);
        host_req = '{rd: 1'b0, wr: 1'b1, socket: s, index: i, wdata: d};
        @(negedge ref_clk);
    endtask : wr
    task automatic rd(input logic s, input logic [7:0] i, input logic [7:0] e, input logic c);
        host_req = '{rd: 1'b1, wr: 1'b0, socket: s, index: i, wdata: 8'h00};
        @(negedge ref_clk);
        host_req = '0;
        `CHK(rd_valid, 1'b1);
        `CHK(rd_claimed, c);
        `CHK(rd_data, e);
        @(negedge ref_clk);
    endtask : rd
    task automatic idle(input int n);
        host_req = '0;
        repeat (n) @(negedge ref_clk);
    endtask : idle
    task automatic t_reset;
        for (int s = 0; s < 2; s++) begin
            rd(s[0], CTRL, 8'h00, 1'b1);
            rd(s[0], SEL, 8'h00, 1'b1);
        end
        `CHK(lamp_n, 1'b1);
        wr(1'b1, SEL, 8'h3b);
        rd(1'b1, SEL, 8'h3b, 1'b1);
        rd(1'b0, SEL, 8'h00, 1'b1);
        rd(1'b0, 8'h50, 8'h00, 1'b0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_chip;
        rd(1'b0, CHIP, {ID_A, REV}, 1'b1);
        rd(1'b1, CHIP, {ID_B, REV}, 1'b1);
        rd(1'b0, CHIP, {ID_A, REV}, 1'b1);
        wr(1'b0, CHIP, 8'hff);
        rd(1'b0, CHIP, {ID_A, REV}, 1'b1);
        $display("test chip info done");
    endtask : t_chip
    task automatic t_ata;
        wr(1'b0, CTRL, 8'hf9);
        idle(2);
        `CHK(mode, 2'h1);
        `CHK(pins[0], 5'h1f);
        `CHK(pins[1], 5'h00);
        wr(1'b1, CTRL, 8'ha9);
        wr(1'b0, CTRL, 8'h58);
        idle(2);
        `CHK(mode, 2'h2);
        `CHK(pins[0], 5'h00);
        `CHK(pins[1], 5'h15);
        rd(1'b0, CTRL, 8'h58, 1'b1);
        $display("test ata done");
    endtask : t_ata
    task automatic t_lamp;
        // lamp reuse on I/O socket 0, then on ATA socket 1
        io_card = 2'h1;
        wr(1'b0, SEL, ata_regs_pkg::EXT_CTRL1);
        wr(1'b0, DAT, 8'h04);
        wr(1'b0, CTRL, 8'h02);
        lamp_on = 2'h3;
        idle(3);
        `CHK(lamp_n, 1'b0);
        `CHK(audio_n, 2'h1);
        lamp_on = 2'h0;
        busy = 2'h2;
        idle(2);
        `CHK(lamp_n, 1'b1);
        busy = 2'h1;
        idle(2);
        `CHK(lamp_n, 1'b0);
        busy = 2'h0;
        wr(1'b1, SEL, ata_regs_pkg::EXT_CTRL1);
        wr(1'b1, DAT, 8'h04);
        wr(1'b1, CTRL, 8'h03);
        lamp_on = 2'h2;
        idle(3);
        `CHK(lamp_n, 1'b0);
        `CHK(audio_n, 2'h3);
        `CHK(mode, 2'h2);
        lamp_on = 2'h0;
        $display("test lamp done");
    endtask : t_lamp
    task automatic t_ext;
        logic [7:0] ix [8] = '{8'h00, 8'h03, 8'h05, 8'h09, 8'h25, 8'h01, 8'h34, 8'h3b};
        logic [7:0] ex [8] = '{8'ha5, 8'ha5, 8'ha5, 8'ha5, 8'h80, 8'h00, IDB[0], IDB[7]};
        for (int k = 0; k < 8; k++) begin
            wr(1'b1, SEL, ix[k]);
            wr(1'b1, DAT, 8'ha5);
            rd(1'b1, DAT, ex[k], 1'b1);
        end
        rd(1'b0, DAT, 8'h04, 1'b1);
        $display("test extended done");
    endtask : t_ext
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    initial begin
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        t_reset();
        t_chip();
        t_ata();
        t_lamp();
        t_ext();
        results();
    end
    // Tests need some 85 cycles; this allows far more
    initial begin
        #200000;
        error_cnt++;
        results();
    end
endmodule : ata_ctrl_ext_index_regs_tb
`default_nettype wire
